// [i2c_ack_busy_control.sv]
`timescale 1ns/1ps
// Contract
// - auto ack driven at ninth clock
// - auto ack enable never self-clears
// - ack sampled on ninth rising sets flag
// - flag cleared by start, disable, reset
// - drive-disable bit gates open-drain transmit output
// - busy leaves on start/address, bit kept
// - interrupt timing register resets to zero
// - timing register takes bit and byte writes
// - soft trigger pulls sda before falling
// - master holds scl after eight or nine clocks, per wait select
module i2c_ack_busy_control
  import i2c_ack_busy_pkg::*;
(
  input  wire logic                         core_clk_i,
  input  wire logic                         rst_n_i,
  input  wire i2c_ack_busy_pkg::reg_req_t   reg_req_i,
  output logic [7:0]                        rd_data_o,
  input  wire logic                         channel_enable_i,
  input  wire logic                         xfer_start_i,
  input  wire logic                         addr_received_i,
  input  wire logic                         busy_enter_i,
  input  wire logic                         master_i,
  input  wire logic                         tx_sda_low_i,
  input  wire logic                         scl_i,
  input  wire logic                         sda_i,
  output i2c_ack_busy_pkg::line_drive_t     line_o,
  output logic                              busy_o,
  output logic [3:0]                        bit_count_o
);
  import i2c_ack_busy_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // line synchronisers

  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic       scl_prev_reg;

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_prev_reg <= 1'b1;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[0], scl_i};
      sda_sync_reg <= {sda_sync_reg[0], sda_i};
      scl_prev_reg <= scl_sync_reg[1];
    end
  end

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  assign scl_s    = scl_sync_reg[1];
  assign sda_s    = sda_sync_reg[1];
  assign scl_rise = scl_s & ~scl_prev_reg;
  assign scl_fall = ~scl_s & scl_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // register access

  logic sel_ctl;
  logic sel_tim;
  logic [7:0] wr_mask;
  logic [7:0] wr_val;
  assign sel_ctl = reg_req_i.addr == SERIAL_BUS_CTL_ADDR;
  assign sel_tim = reg_req_i.addr == INT_TIMING_SEL_ADDR;

  always_comb
  begin
    wr_mask = 8'hff;
    wr_val  = reg_req_i.wdata;
    if (reg_req_i.bit_op)
    begin
      wr_mask = 8'h01 << reg_req_i.bit_sel;
      wr_val  = reg_req_i.wdata[0] ? wr_mask : 8'h00;
    end
  end

  logic wr_ctl;
  logic wr_tim;
  assign wr_ctl = reg_req_i.wr & sel_ctl;
  assign wr_tim = reg_req_i.wr & sel_tim;

  logic tx_drive_disable_reg;
  logic auto_ack_enable_reg;
  logic ack_detected_flag_reg;
  logic [5:0] interrupt_timing_reg;

  // hardware never touches these two bits
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tx_drive_disable_reg <= SERIAL_BUS_CTL_RESET[TX_DRIVE_DISABLE_BIT];
      auto_ack_enable_reg  <= SERIAL_BUS_CTL_RESET[AUTO_ACK_ENABLE_BIT];
    end
    else if (wr_ctl)
    begin
      if (wr_mask[TX_DRIVE_DISABLE_BIT])
        tx_drive_disable_reg <= wr_val[TX_DRIVE_DISABLE_BIT];
      if (wr_mask[AUTO_ACK_ENABLE_BIT])
        auto_ack_enable_reg <= wr_val[AUTO_ACK_ENABLE_BIT];
    end
  end

  logic soft_ack_trigger;
  logic wait_release;
  assign soft_ack_trigger = wr_ctl & wr_mask[SOFT_ACK_TRIGGER_BIT]
                          & wr_val[SOFT_ACK_TRIGGER_BIT];
  assign wait_release = wr_tim & wr_mask[WAIT_RELEASE_BIT]
                      & wr_val[WAIT_RELEASE_BIT];

  // release bit self-clears; it only ever reads back as zero
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      interrupt_timing_reg <= INT_TIMING_SEL_RESET[5:0];
    else if (wr_tim)
      interrupt_timing_reg <= ((interrupt_timing_reg & ~wr_mask[5:0])
                             | (wr_val[5:0] & wr_mask[5:0]))
                             & INT_TIMING_WR_MASK[5:0]
                             & ~(6'h01 << WAIT_RELEASE_BIT);
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rd_data_o <= 8'h00;
    else if (reg_req_i.rd)
    begin
      rd_data_o <= 8'h00;
      if (sel_ctl)
      begin
        rd_data_o[TX_DRIVE_DISABLE_BIT] <= tx_drive_disable_reg;
        rd_data_o[ACK_DETECTED_BIT]     <= ack_detected_flag_reg;
        rd_data_o[AUTO_ACK_ENABLE_BIT]  <= auto_ack_enable_reg;
      end
      else if (sel_tim)
        rd_data_o <= {1'b0, scl_s, interrupt_timing_reg[5:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit counting on falling scl

  logic [3:0] bit_cnt_reg;
  logic [3:0] bit_cnt_next;
  assign bit_cnt_next = (bit_cnt_reg == NINTH_CLOCK) ? 4'h1
                                                     : bit_cnt_reg + 4'h1;

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      bit_cnt_reg <= BIT_COUNT_RESET;
    else if (xfer_start_i || !channel_enable_i)
      bit_cnt_reg <= BIT_COUNT_RESET;
    else if (scl_fall)
      bit_cnt_reg <= bit_cnt_next;
  end
  assign bit_count_o = bit_cnt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // acknowledge drive and detection

  logic ack_drive_reg;
  logic ack_seen_high_reg;

  // released only on disable or on the falling edge that ends a seen high phase
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ack_drive_reg     <= 1'b0;
      ack_seen_high_reg <= 1'b0;
    end
    else if (!channel_enable_i)
    begin
      ack_drive_reg     <= 1'b0;
      ack_seen_high_reg <= 1'b0;
    end
    else if (scl_fall && auto_ack_enable_reg && bit_cnt_next == EIGHTH_CLOCK)
    begin
      ack_drive_reg     <= 1'b1;
      ack_seen_high_reg <= 1'b0;
    end
    else if (soft_ack_trigger)
    begin
      ack_drive_reg     <= 1'b1;
      ack_seen_high_reg <= scl_s;
    end
    else if (ack_drive_reg)
    begin
      if (scl_rise)
        ack_seen_high_reg <= 1'b1;
      if (scl_fall && ack_seen_high_reg)
      begin
        ack_drive_reg     <= 1'b0;
        ack_seen_high_reg <= 1'b0;
      end
    end
  end

  // set wins over the start-instruction clear
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ack_detected_flag_reg <= 1'b0;
    else if (!channel_enable_i)
      ack_detected_flag_reg <= 1'b0;
    else if (scl_rise && bit_cnt_reg == EIGHTH_CLOCK && !sda_s)
      ack_detected_flag_reg <= 1'b1;
    else if (xfer_start_i)
      ack_detected_flag_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // wait hold on scl, busy mode

  logic wait_hold_reg;
  logic [1:0] wait_sel;
  assign wait_sel = interrupt_timing_reg[WAIT_SEL_HI_BIT:WAIT_SEL_LO_BIT];

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      wait_hold_reg <= 1'b0;
    else if (!channel_enable_i || wait_release || xfer_start_i)
      wait_hold_reg <= 1'b0;
    else if (scl_fall && master_i
             && ((wait_sel == WAIT_8_CLOCK && bit_cnt_next == EIGHTH_CLOCK)
              || (wait_sel == WAIT_9_CLOCK && bit_cnt_next == NINTH_CLOCK)))
      wait_hold_reg <= 1'b1;
  end

  // busy exit leaves the drive-disable bit untouched
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      busy_o <= 1'b0;
    else if (xfer_start_i || addr_received_i || !channel_enable_i)
      busy_o <= 1'b0;
    else if (busy_enter_i)
      busy_o <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // open-drain line drive, low only

  logic tx_pull;
  assign tx_pull = channel_enable_i & ~tx_drive_disable_reg
                 & tx_sda_low_i;

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      line_o <= '0;
    else
    begin
      line_o.sda_out <= 1'b0;
      // disable drops the pins on the next clock edge, not a cycle after the drive regs clear
      line_o.sda_oe  <= tx_pull
                      | (ack_drive_reg & channel_enable_i);
      line_o.scl_out <= 1'b0;
      line_o.scl_oe  <= wait_hold_reg & channel_enable_i;
    end
  end

endmodule // i2c_ack_busy_control

// [i2c_ack_busy_pkg.sv]
package i2c_ack_busy_pkg;

  localparam logic [15:0] SERIAL_BUS_CTL_ADDR  = 16'hff61;
  localparam logic [15:0] INT_TIMING_SEL_ADDR  = 16'hff63;
  localparam logic [7:0]  SERIAL_BUS_CTL_RESET = 8'h00;
  localparam logic [7:0]  INT_TIMING_SEL_RESET = 8'h00;

  // serial bus control register fields
  localparam int TX_DRIVE_DISABLE_BIT  = 7;
  localparam int ACK_DETECTED_BIT      = 6;
  localparam int AUTO_ACK_ENABLE_BIT   = 5;
  localparam int SOFT_ACK_TRIGGER_BIT  = 4;

  // interrupt timing register fields
  localparam int CLOCK_LINE_LEVEL_BIT  = 6;
  localparam int WAIT_RELEASE_BIT      = 2;
  localparam int WAIT_SEL_HI_BIT       = 1;
  localparam int WAIT_SEL_LO_BIT       = 0;
  localparam logic [7:0] INT_TIMING_WR_MASK = 8'h3f;

  localparam logic [1:0] WAIT_8_CLOCK = 2'b10;
  localparam logic [1:0] WAIT_9_CLOCK = 2'b11;

  localparam logic [3:0] BIT_COUNT_RESET = 4'h0;
  localparam logic [3:0] EIGHTH_CLOCK    = 4'h8;
  localparam logic [3:0] NINTH_CLOCK     = 4'h9;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        bit_op;
    logic [2:0]  bit_sel;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } reg_req_t;

  typedef struct packed {
    logic sda_out;
    logic sda_oe;
    logic scl_out;
    logic scl_oe;
  } line_drive_t;

endpackage

// [i2c_ack_busy_chk.sv]
`timescale 1ns/1ps
module i2c_ack_busy_chk
  import i2c_ack_busy_pkg::*;
(
  input wire logic                         core_clk_i,
  input wire logic                         rst_n_i,
  input wire i2c_ack_busy_pkg::reg_req_t   reg_req_i,
  input wire logic [7:0]                   rd_data_o,
  input wire logic                         channel_enable_i,
  input wire logic                         xfer_start_i,
  input wire logic                         addr_received_i,
  input wire logic                         busy_enter_i,
  input wire logic                         master_i,
  input wire logic                         tx_sda_low_i,
  input wire logic                         scl_i,
  input wire logic                         sda_i,
  input wire i2c_ack_busy_pkg::line_drive_t line_o,
  input wire logic                         busy_o,
  input wire logic [3:0]                   bit_count_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  //////////////////////////////////////////////////////////////////////////
  a_timing_read:
    assert property (reg_req_i.rd && reg_req_i.addr == INT_TIMING_SEL_ADDR
      |=> rd_data_o[7] == 1'b0 && rd_data_o[2] == 1'b0) else $error("rd");
  a_read_holds:
    assert property (!reg_req_i.rd |=> $stable(rd_data_o)) else $error("rh");
  a_busy_exit:
    assert property ((xfer_start_i || addr_received_i) && !busy_enter_i
      |=> !busy_o) else $error("busy");
  a_disable_clear:
    assert property (!channel_enable_i |=> !line_o.sda_oe && !line_o.scl_oe
      && !busy_o && bit_count_o == 4'h0) else $error("dis");
  a_open_drain:
    assert property (line_o.sda_out == 1'b0 && line_o.scl_out == 1'b0)
      else $error("od");
  // ack raised at count 8 must hold at least four core cycles, never a glitch
  a_ack_hold:
    assert property ($rose(line_o.sda_oe) && !tx_sda_low_i
      && bit_count_o == 4'h8 |-> line_o.sda_oe [*4]) else $error("ack");
  a_wait_entry:
    assert property ($rose(line_o.scl_oe) |-> master_i
      && bit_count_o >= 4'h8) else $error("wait");
  a_wait_release:
    assert property (line_o.scl_oe && reg_req_i.wr && reg_req_i.bit_op
      && reg_req_i.addr == INT_TIMING_SEL_ADDR
      && reg_req_i.bit_sel == 3'h2 && reg_req_i.wdata[0]
      |-> ##[1:3] !line_o.scl_oe) else $error("rel");
endmodule // i2c_ack_busy_chk

bind i2c_ack_busy_control i2c_ack_busy_chk i_chk (.core_clk_i, .rst_n_i,
  .reg_req_i, .rd_data_o, .channel_enable_i, .xfer_start_i,
  .addr_received_i, .busy_enter_i, .master_i, .tx_sda_low_i, .scl_i,
  .sda_i, .line_o, .busy_o, .bit_count_o);

// [i2c_far_end.sv]
`timescale 1ns/1ps
module i2c_far_end
(
  input  wire logic  sda_i,
  output logic       scl_o = 1'b1,
  output logic       sda_o = 1'b1,
  output logic [8:0] seen_o = 9'h000
);
  // released sda rises to the pull-up, so no stale low lingers
  task automatic clock_bits(input int n, input int ack_at, input logic park);
    #13;
    for (int k = 0; k < n; k++)
    begin
      #50 sda_o = (k != ack_at);
      #250 scl_o = 1'b1;
      #50 seen_o = {seen_o[7:0], sda_i};
      #50 scl_o = 1'b0;
    end
    #50 sda_o = 1'b1;
    if (park) scl_o = 1'b1;
  endtask
endmodule // i2c_far_end

// [tb.sv]
`timescale 1ns/1ps
module tb;
  import i2c_ack_busy_pkg::*;
  localparam logic [15:0] ctl = SERIAL_BUS_CTL_ADDR;
  localparam logic [15:0] tim = INT_TIMING_SEL_ADDR;
  logic        core_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        channel_enable_i = 1'b0;
  logic        master_i = 1'b0;
  logic        tx_sda_low_i = 1'b0;
  logic [2:0]  ev = 3'b000;
  reg_req_t    reg_req_i = '0;
  line_drive_t line_o;
  logic [7:0]  rd_data_o;
  logic        busy_o;
  logic [3:0]  bit_count_o;
  wire         far_scl;
  wire         far_sda;
  wire [8:0]   seen;
  wire         scl_i = far_scl & ~line_o.scl_oe;
  wire         sda_i = far_sda & ~line_o.sda_oe;
  int          mismatches = 0;
  int          comparisons = 0;
  i2c_ack_busy_control i_dut (.core_clk_i, .rst_n_i, .reg_req_i, .rd_data_o,
    .channel_enable_i, .xfer_start_i(ev[0]), .addr_received_i(ev[1]),
    .busy_enter_i(ev[2]), .master_i, .tx_sda_low_i, .scl_i, .sda_i,
    .line_o, .busy_o, .bit_count_o);
  i2c_far_end i_far (.sda_i, .scl_o(far_scl), .sda_o(far_sda),
    .seen_o(seen));
  always #25 core_clk_i = ~core_clk_i;
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic rd, input logic bo, input logic [2:0] s,
                     input logic [15:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    reg_req_i = '{rd, !rd, bo, s, a, d};
    @(negedge core_clk_i);
    reg_req_i = '0;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    bus(1'b1, 1'b0, 3'h0, a, 8'h00);
    chk(rd_data_o, exp);
  endtask
  task automatic pulse(input int i);
    @(negedge core_clk_i);
    ev[i] = 1'b1;
    @(negedge core_clk_i);
    ev = 3'b000;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  task automatic finish_test();
    if (mismatches == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd_chk(tim, 8'h40);
    bus(1'b0, 1'b0, 3'h0, tim, 8'hff);
    rd_chk(tim, 8'h7b);
    bus(1'b0, 1'b1, 3'h5, tim, 8'h00);
    rd_chk(tim, 8'h5b);
    bus(1'b0, 1'b0, 3'h0, tim, 8'h00);
  endtask
  task automatic t_acks();
    bus(1'b0, 1'b0, 3'h0, ctl, 8'h20);
    pulse(0);
    i_far.clock_bits(9, -1, 1'b1);
    chk(8'(seen[0]), 8'h00);
    wait_n(10);
    chk(8'(line_o.sda_oe), 8'h00);
    chk({4'h0, bit_count_o}, 8'h09);
    rd_chk(ctl, 8'h60);
    pulse(0);
    rd_chk(ctl, 8'h20);
    bus(1'b0, 1'b0, 3'h0, ctl, 8'h00);
    bus(1'b0, 1'b0, 3'h0, tim, 8'h02);
    pulse(0);
    i_far.clock_bits(8, -1, 1'b0);
    bus(1'b0, 1'b1, 3'h4, ctl, 8'h01);
    wait_n(3);
    chk(8'(line_o.sda_oe), 8'h01);
    i_far.clock_bits(1, -1, 1'b1);
    chk(8'(seen[0]), 8'h00);
    rd_chk(ctl, 8'h40);
    channel_enable_i = 1'b0;
    wait_n(2);
    rd_chk(ctl, 8'h00);
    channel_enable_i = 1'b1;
  endtask
  task automatic t_detect_wait();
    bus(1'b0, 1'b0, 3'h0, ctl, 8'h80);
    pulse(0);
    i_far.clock_bits(9, 8, 1'b1);
    rd_chk(ctl, 8'hc0);
    master_i = 1'b1;
    pulse(0);
    i_far.clock_bits(8, -1, 1'b0);
    wait_n(8);
    chk(8'(line_o.scl_oe), 8'h01);
    bus(1'b0, 1'b1, 3'h2, tim, 8'h01);
    wait_n(3);
    chk(8'(line_o.scl_oe), 8'h00);
    master_i = 1'b0;
    i_far.clock_bits(1, -1, 1'b1);
    bus(1'b0, 1'b0, 3'h0, tim, 8'h03);
    master_i = 1'b1;
    pulse(0);
    i_far.clock_bits(9, -1, 1'b0);
    wait_n(8);
    chk(8'(line_o.scl_oe), 8'h01);
    bus(1'b0, 1'b1, 3'h2, tim, 8'h01);
    wait_n(3);
    chk(8'(line_o.scl_oe), 8'h00);
    master_i = 1'b0;
    i_far.clock_bits(0, -1, 1'b1);
  endtask
  task automatic t_busy_drive();
    pulse(2);
    chk(8'(busy_o), 8'h01);
    pulse(0);
    chk(8'(busy_o), 8'h00);
    rd_chk(ctl, 8'h80);
    pulse(2);
    pulse(1);
    chk(8'(busy_o), 8'h00);
    tx_sda_low_i = 1'b1;
    wait_n(3);
    chk(8'(line_o.sda_oe), 8'h00);
    bus(1'b0, 1'b0, 3'h0, ctl, 8'h00);
    wait_n(3);
    chk(8'(line_o.sda_oe), 8'h01);
    tx_sda_low_i = 1'b0;
  endtask
  initial
  begin
    wait_n(6);
    rst_n_i = 1'b1;
    t_regs();
    channel_enable_i = 1'b1;
    t_acks();
    t_detect_wait();
    t_busy_drive();
    finish_test();
  end
  // about 45 link bits of 400 ns; ample margin
  initial
  begin
    #500000;
    mismatches++;
    finish_test();
  end
endmodule // tb
